// ### psm_defines.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * power-source monitor register bank.
 * Assumes it is included by bare name from the register bank design file.
 */
`ifndef PSM_DEFINES_SVH
`define PSM_DEFINES_SVH

// ---------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------
`define PSM_ADDR_BATT_CFG 8'h6A
`define PSM_ADDR_STATUS 8'h6F
`define PSM_ADDR_WAKE_CTRL 8'hD0
`define PSM_ADDR_WIN_ONE 8'hDD

// ---------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------
`define PSM_RST_BATT_CFG 8'hF8
`define PSM_RST_WAKE_CTRL 8'h00
`define PSM_RST_WIN_ONE 8'h00

// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define PSM_BIT_DB_HI 7
`define PSM_BIT_DB_LO 6
`define PSM_BIT_BATT_TWO_EN 5
`define PSM_BIT_BATT_ONE_EN 4
`define PSM_BIT_ADAPTER_EN 3
`define PSM_BIT_BATT_TWO_LOW 6
`define PSM_BIT_BATT_ONE_LOW 5
`define PSM_BIT_ADAPTER_OK 4
`define PSM_BIT_WAKE_EN 0
`define PSM_BIT_WIN_MODE 7
`define PSM_BIT_SHIFT_HI 6
`define PSM_BIT_SHIFT_LO 3
`define PSM_BIT_VSEL_HI 2
`define PSM_BIT_VSEL_LO 0

// ---------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------
`define PSM_CLK_PERIOD_NS 10
`define PSM_RTC_PERIOD_NS 30000
`define PSM_RTC_CYCLES (`PSM_RTC_PERIOD_NS / `PSM_CLK_PERIOD_NS)
`define PSM_WAKE_PERIOD_NS 1000000000
`define PSM_WAKE_HALF_CYCLES (`PSM_WAKE_PERIOD_NS / `PSM_CLK_PERIOD_NS / 2)
`define PSM_DB_CODE0 4
`define PSM_DB_CODE1 32
`define PSM_DB_CODE2 64
`define PSM_DB_CODE3 128

`endif

// ### psm_pkg.sv
/*
 * Types shared by the power-source monitor register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package psm_pkg;
    typedef logic [7:0] psm_byte_t;
    typedef logic [1:0] psm_debounce_sel_t;
    typedef logic [2:0] psm_voltage_sel_t;
    typedef logic [3:0] psm_shift_code_t;
    typedef enum logic {PSM_MODE_POWER_GOOD, PSM_MODE_COMPARATOR} psm_comp_mode_t;
endpackage : psm_pkg

`default_nettype wire

// ### psm_regs.sv
/*
 * Power-source monitor register bank: battery low detection with debounce,
 * adapter presence status, 1 Hz wake clock and window comparator one setup.
 * Assumes a host-interface front end drives the register port on mclk and
 * that comparator results arrive asynchronously from the analog side.
 */
`include "psm_defines.svh"
`default_nettype none

module psm_regs #(
    parameter int RTC_CYCLES = `PSM_RTC_CYCLES,
    parameter int WAKE_HALF_CYCLES = `PSM_WAKE_HALF_CYCLES
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire psm_pkg::psm_byte_t regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    input wire logic battOneBelowRaw,
    input wire logic battTwoBelowRaw,
    input wire logic adapterPresentRaw,
    output logic battOneDetectOn,
    output logic battTwoDetectOn,
    output logic adapterComparatorOn,
    output logic wakeClk,
    output psm_pkg::psm_comp_mode_t windowCompMode,
    output psm_pkg::psm_voltage_sel_t windowVoltageSel,
    output psm_pkg::psm_shift_code_t windowShiftCode
);
    import psm_pkg::*;

    if (RTC_CYCLES < 2 || RTC_CYCLES > 65535) begin : gCheckRtc
        $error("RTC_CYCLES out of range");
    end
    if (WAKE_HALF_CYCLES < 1 || WAKE_HALF_CYCLES > 2**30) begin : gCheckWake
        $error("WAKE_HALF_CYCLES out of range");
    end

    // ---------------------------------------------------------------------
    // register storage
    // ---------------------------------------------------------------------
    psm_byte_t battCfg_reg;
    psm_byte_t wakeCtrl_reg;
    psm_byte_t winOne_reg;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            battCfg_reg <= `PSM_RST_BATT_CFG;
            wakeCtrl_reg <= `PSM_RST_WAKE_CTRL;
            winOne_reg <= `PSM_RST_WIN_ONE;
        end else if (regWrEn) begin
            if (regAddr == `PSM_ADDR_BATT_CFG) begin
                battCfg_reg <= regWrData;
            end else if (regAddr == `PSM_ADDR_WAKE_CTRL) begin
                wakeCtrl_reg <= regWrData;
            end else if (regAddr == `PSM_ADDR_WIN_ONE) begin
                winOne_reg <= regWrData;
            end
        end
    end

    logic [1:0] dbSel;
    logic [1:0] detectEn;
    assign dbSel = battCfg_reg[`PSM_BIT_DB_HI:`PSM_BIT_DB_LO];
    assign detectEn = {battCfg_reg[`PSM_BIT_BATT_TWO_EN], battCfg_reg[`PSM_BIT_BATT_ONE_EN]};

    // ---------------------------------------------------------------------
    // configuration outputs, each from a flop
    // ---------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            battOneDetectOn <= 1'b0;
            battTwoDetectOn <= 1'b0;
            adapterComparatorOn <= 1'b0;
            windowCompMode <= PSM_MODE_POWER_GOOD;
            windowVoltageSel <= 3'h0;
            windowShiftCode <= 4'h0;
        end else begin
            battOneDetectOn <= detectEn[0];
            battTwoDetectOn <= detectEn[1];
            adapterComparatorOn <= battCfg_reg[`PSM_BIT_ADAPTER_EN];
            windowCompMode <= psm_comp_mode_t'(winOne_reg[`PSM_BIT_WIN_MODE]);
            windowVoltageSel <= winOne_reg[`PSM_BIT_VSEL_HI:`PSM_BIT_VSEL_LO];
            windowShiftCode <= winOne_reg[`PSM_BIT_SHIFT_HI:`PSM_BIT_SHIFT_LO];
        end
    end

    // ---------------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------------
    logic [2:0] rawMeta_reg;
    logic [2:0] rawSync_reg;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rawMeta_reg <= 3'h0;
            rawSync_reg <= 3'h0;
        end else begin
            rawMeta_reg <= {adapterPresentRaw, battTwoBelowRaw, battOneBelowRaw};
            rawSync_reg <= rawMeta_reg;
        end
    end

    // ---------------------------------------------------------------------
    // rtc period enable from divider
    // ---------------------------------------------------------------------
    logic [15:0] rtcDiv_reg;
    logic rtcTick;
    assign rtcTick = (rtcDiv_reg == 16'(RTC_CYCLES - 1));
    always_ff @(posedge mclk) begin
        if (!rstn || rtcTick) begin
            rtcDiv_reg <= 16'h0000;
        end else begin
            rtcDiv_reg <= rtcDiv_reg + 16'h0001;
        end
    end

    logic [7:0] dbLimit;
    always_comb begin
        case (dbSel)
            2'b00: dbLimit = 8'(`PSM_DB_CODE0);
            2'b01: dbLimit = 8'(`PSM_DB_CODE1);
            2'b10: dbLimit = 8'(`PSM_DB_CODE2);
            default: dbLimit = 8'(`PSM_DB_CODE3);
        endcase
    end

    // ---------------------------------------------------------------------
    // battery debounce, one per battery
    // ---------------------------------------------------------------------
    // counter only advances on rtc ticks, so a glitch shorter than one
    // period can still be missed entirely; that is the intended filter
    // each flag lives in its own generate scope so that no variable is
    // written by two processes; the vector below only collects them
    logic [1:0] battLow;
    genvar gi;
    for (gi = 0; gi < 2; gi++) begin : gBatt
        logic [7:0] dbCnt_reg;
        logic flag_reg;
        always_ff @(posedge mclk) begin
            if (!rstn || !detectEn[gi]) begin
                dbCnt_reg <= 8'h00;
                flag_reg <= 1'b0;
            end else if (rawSync_reg[gi] == flag_reg) begin
                dbCnt_reg <= 8'h00;
            end else if (rtcTick) begin
                if (dbCnt_reg + 8'h01 >= dbLimit) begin
                    flag_reg <= rawSync_reg[gi];
                    dbCnt_reg <= 8'h00;
                end else begin
                    dbCnt_reg <= dbCnt_reg + 8'h01;
                end
            end
        end
        assign battLow[gi] = flag_reg;
    end

    logic adapterOk_reg;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            adapterOk_reg <= 1'b0;
        end else begin
            // comparator off means nothing is sensed, so report removed
            adapterOk_reg <= rawSync_reg[2] & battCfg_reg[`PSM_BIT_ADAPTER_EN];
        end
    end

    // ---------------------------------------------------------------------
    // 1 Hz wake clock
    // ---------------------------------------------------------------------
    logic [29:0] wakeCnt_reg;
    always_ff @(posedge mclk) begin
        if (!rstn || !wakeCtrl_reg[`PSM_BIT_WAKE_EN]) begin
            wakeCnt_reg <= 30'h0;
            wakeClk <= 1'b0;
        end else if (wakeCnt_reg == 30'(WAKE_HALF_CYCLES - 1)) begin
            wakeCnt_reg <= 30'h0;
            wakeClk <= ~wakeClk;
        end else begin
            wakeCnt_reg <= wakeCnt_reg + 30'h1;
        end
    end

    // ---------------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------------
    psm_byte_t statusByte;
    always_comb begin
        statusByte = 8'h00;
        statusByte[`PSM_BIT_BATT_TWO_LOW] = battLow[1];
        statusByte[`PSM_BIT_BATT_ONE_LOW] = battLow[0];
        statusByte[`PSM_BIT_ADAPTER_OK] = adapterOk_reg;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            if (regAddr == `PSM_ADDR_BATT_CFG) begin
                regRdData <= battCfg_reg;
            end else if (regAddr == `PSM_ADDR_STATUS) begin
                regRdData <= statusByte;
            end else if (regAddr == `PSM_ADDR_WAKE_CTRL) begin
                regRdData <= wakeCtrl_reg;
            end else if (regAddr == `PSM_ADDR_WIN_ONE) begin
                regRdData <= winOne_reg;
            end else begin
                regRdData <= 8'h00;
            end
        end
    end
endmodule : psm_regs

`default_nettype wire

// ### psm_regs_properties.sv
/*
 * Port checker for the power-source monitor register bank.
 * Assumes it is bound into psm_regs, one clock mclk, rstn active low.
 */
`default_nettype none

// ----
// checker
// ----
module psm_regs_properties #(
    parameter int WAKE_HALF_CYCLES = 8
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire psm_pkg::psm_byte_t regWrData,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic battOneDetectOn,
    input wire logic battTwoDetectOn,
    input wire logic wakeClk,
    input wire psm_pkg::psm_comp_mode_t windowCompMode,
    input wire psm_pkg::psm_voltage_sel_t windowVoltageSel,
    input wire psm_pkg::psm_shift_code_t windowShiftCode
);
    timeunit 1ns;
    timeprecision 1ns;
    import psm_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    int lowCnt_reg;
    // low-time count; the first rise may come well after a full half, none comes earlier
    always_ff @(posedge mclk) begin
        if (!rstn || wakeClk) begin
            lowCnt_reg <= 0;
        end else begin
            lowCnt_reg <= lowCnt_reg + 1;
        end
    end
    sequence s_wr(logic [7:0] a);
        regWrEn && regAddr == a;
    endsequence
    sequence s_rd(logic [7:0] a);
        regRdEn && regAddr == a;
    endsequence
    a_two_enable_mirror: assert property (
        s_wr(8'h6A) ##2 1 |-> battTwoDetectOn == $past(regWrData[5], 2))
        else $error("battery two enable not mirrored");
    a_one_enable_mirror: assert property (
        s_wr(8'h6A) ##2 1 |-> battOneDetectOn == $past(regWrData[4], 2))
        else $error("battery one enable not mirrored");
    a_window_fields_out: assert property (
        s_wr(8'hDD) ##2 1 |->
        {windowCompMode, windowShiftCode, windowVoltageSel} == $past(regWrData, 2))
        else $error("window fields not mirrored");
    a_config_read_back: assert property (
        s_wr(8'h6A) ##1 !regWrEn ##1 (s_rd(8'h6A) and !regWrEn)
        |=> regRdData == $past(regWrData, 3))
        else $error("config byte not read back");
    a_status_reserved_zero: assert property (
        s_rd(8'h6F) |=> regRdData[7] == 1'h0 && regRdData[3:0] == 4'h0)
        else $error("status reserved bits set");
    a_one_disabled_hold: assert property (
        (!battOneDetectOn)[*3] ##0 s_rd(8'h6F) |=> !regRdData[5])
        else $error("battery one flag set while disabled");
    a_two_disabled_hold: assert property (
        (!battTwoDetectOn)[*3] ##0 s_rd(8'h6F) |=> !regRdData[6])
        else $error("battery two flag set while disabled");
    a_read_data_holds: assert property (!regRdEn |=> $stable(regRdData))
        else $error("read data changed without read");
    a_wake_half_period: assert property (
        $rose(wakeClk) |-> lowCnt_reg >= WAKE_HALF_CYCLES - 2)
        else $error("wake clock low phase too short");
endmodule : psm_regs_properties

bind psm_regs psm_regs_properties #(.WAKE_HALF_CYCLES(WAKE_HALF_CYCLES)) u_chk (
    .mclk(mclk),
    .rstn(rstn),
    .regAddr(regAddr),
    .regWrEn(regWrEn),
    .regWrData(regWrData),
    .regRdEn(regRdEn),
    .regRdData(regRdData),
    .battOneDetectOn(battOneDetectOn),
    .battTwoDetectOn(battTwoDetectOn),
    .wakeClk(wakeClk),
    .windowCompMode(windowCompMode),
    .windowVoltageSel(windowVoltageSel),
    .windowShiftCode(windowShiftCode)
);

`default_nettype wire

// ### psm_regs_tb_top.sv
/*
 * Self-checking bench for psm_regs: byte-port tasks and call sequences.
 * Assumes psm_pkg, psm_regs and its checker are compiled before it.
 */
`default_nettype none

// ----
// bench
// ----
module psm_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import psm_pkg::*;
    localparam int RTC = 4;
    localparam int WH = 8;
    logic mclk = 1'h0, rstn = 1'h0, regWrEn = 1'h0, regRdEn = 1'h0;
    logic battOneBelowRaw = 1'h0, battTwoBelowRaw = 1'h0, adapterPresentRaw = 1'h0;
    logic [7:0] regAddr = 8'h00;
    psm_byte_t regWrData = 8'h00;
    logic [7:0] regRdData;
    logic battOneDetectOn, battTwoDetectOn, adapterComparatorOn, wakeClk;
    psm_comp_mode_t windowCompMode;
    psm_voltage_sel_t windowVoltageSel;
    psm_shift_code_t windowShiftCode;
    int n_fail = 0, compares = 0, n, cnt;
    logic prev;
    logic [7:0] v;

    psm_regs #(.RTC_CYCLES(RTC), .WAKE_HALF_CYCLES(WH)) DUT (
        .mclk(mclk),
        .rstn(rstn),
        .regAddr(regAddr),
        .regWrEn(regWrEn),
        .regWrData(regWrData),
        .regRdEn(regRdEn),
        .regRdData(regRdData),
        .battOneBelowRaw(battOneBelowRaw),
        .battTwoBelowRaw(battTwoBelowRaw),
        .adapterPresentRaw(adapterPresentRaw),
        .battOneDetectOn(battOneDetectOn),
        .battTwoDetectOn(battTwoDetectOn),
        .adapterComparatorOn(adapterComparatorOn),
        .wakeClk(wakeClk),
        .windowCompMode(windowCompMode),
        .windowVoltageSel(windowVoltageSel),
        .windowShiftCode(windowShiftCode)
    );

    always #5 mclk = ~mclk;

    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : tick
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'h1;
        tick(1);
        regWrEn = 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        tick(1);
        regAddr = a;
        regRdEn = 1'h1;
        tick(1);
        regRdEn = 1'h0;
        chk(what, exp, regRdData);
    endtask : rd
    task automatic end_of_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (30000) @(posedge mclk);
        n_fail++;
        end_of_test();
    end

    initial begin
        tick(5);
        rstn = 1'h1;
        rd(8'h6A, 8'hF8, "battCfg");
        rd(8'h6F, 8'h00, "status");
        rd(8'hD0, 8'h00, "wakeCtrl");
        rd(8'hDD, 8'h00, "winOne");
        rd(8'h00, 8'h00, "unmapped");
        chk("battOneOn", 8'h01, 8'(battOneDetectOn));
        chk("battTwoOn", 8'h01, 8'(battTwoDetectOn));
        chk("adapterOn", 8'h01, 8'(adapterComparatorOn));
        $display("test reset done");
        for (int i = 0; i < 10; i++) begin
            v = {i[0], i[3:0], i[2:0]};
            wr(8'hDD, v);
            tick(1);
            chk("winMode", 8'(i[0]), 8'(windowCompMode));
            chk("winShift", 8'(i[3:0]), 8'(windowShiftCode));
            chk("winSel", 8'(i[2:0]), 8'(windowVoltageSel));
            rd(8'hDD, v, "winOne");
        end
        $display("test window done");
        // each code: flag must still be old just before N-1 ticks, new after N
        for (int c = 0; c < 4; c++) begin
            n = (c == 0) ? 4 : 32 << (c - 1);
            wr(8'h6A, {c[1:0], 6'h38});
            rd(8'h6A, {c[1:0], 6'h38}, "battCfg");
            for (int lv = 1; lv >= 0; lv--) begin
                battOneBelowRaw = lv[0];
                tick((n - 1) * RTC - 2);
                rd(8'h6F, lv ? 8'h00 : 8'h20, "statusEarly");
                tick(RTC + 4);
                rd(8'h6F, lv ? 8'h20 : 8'h00, "statusLate");
            end
        end
        $display("test debounce done");
        // shortest debounce code, else the flag needs 128 periods
        wr(8'h6A, 8'h38);
        battTwoBelowRaw = 1'h1;
        adapterPresentRaw = 1'h1;
        tick(4 * RTC + 4);
        rd(8'h6F, 8'h50, "status");
        wr(8'h6A, 8'h08);
        battOneBelowRaw = 1'h1;
        tick(4 * RTC + 4);
        rd(8'h6F, 8'h10, "status");
        chk("battTwoOn", 8'h00, 8'(battTwoDetectOn));
        chk("battOneOn", 8'h00, 8'(battOneDetectOn));
        chk("adapterOn", 8'h01, 8'(adapterComparatorOn));
        adapterPresentRaw = 1'h0;
        wr(8'h6F, 8'hFF);
        tick(4);
        rd(8'h6F, 8'h00, "status");
        adapterPresentRaw = 1'h1;
        wr(8'h6A, 8'h00);
        tick(4);
        rd(8'h6F, 8'h00, "statusAdapterOff");
        chk("adapterOn", 8'h00, 8'(adapterComparatorOn));
        $display("test status done");
        wr(8'hD0, 8'hFE);
        tick(2 * WH);
        rd(8'hD0, 8'hFE, "wakeCtrl");
        chk("wakeIdle", 8'h00, 8'(wakeClk));
        wr(8'hD0, 8'h01);
        cnt = 0;
        prev = wakeClk;
        repeat (4 * WH + WH / 2) begin
            tick(1);
            if (wakeClk !== prev) begin
                cnt++;
            end
            prev = wakeClk;
        end
        chk("wakeEdges", 8'h04, 8'(cnt));
        wr(8'hD0, 8'h00);
        // wait past the next two natural toggles, where a clock that ignores the bit is low again
        tick(WH + 2);
        chk("wakeOff", 8'h00, 8'(wakeClk));
        $display("test wake done");
        end_of_test();
    end
endmodule : psm_regs_tb_top

`default_nettype wire
